// [hw/slim_top.sv]
// Stroke limit logic: limit mapping, motion gating, warning, stop, registers
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// One address end: source choice, contact polarity and motion gating
// ---------------------------------------------------------------------
module slim_limit_gate
(
  input  wire logic dir0_sw_i,
  input  wire logic dir1_sw_i,
  input  wire logic host_sw_i,
  input  wire logic src_sel_i,
  input  wire logic dir_sel_i,
  input  wire logic auto_on_i,
  input  wire logic honour_i,
  input  wire logic req_i,
  output logic      hit_o,
  output logic      allow_o,
  output logic      stop_o
);

  logic pin_sw;
  logic raw_limit;

  // Which pin sits at this end depends on the travel direction
  assign pin_sw    = dir_sel_i ? dir1_sw_i : dir0_sw_i;
  // Open contact means limit; auto-on masks the pins only
  assign raw_limit = src_sel_i ? ~host_sw_i
                               : (~pin_sw & ~auto_on_i);
  assign hit_o     = raw_limit & honour_i;
  // Only motion toward this end is held back
  assign allow_o   = req_i & ~hit_o;
  assign stop_o    = req_i & hit_o;

endmodule : slim_limit_gate

module slim_top
  import slim_pkg::*;
(
  input  wire logic            mclk_i,
  input  wire logic            reset_i,
  // Avalon-MM slave
  input  wire logic [3:0]      avs_address_i,
  input  wire logic            avs_read_i,
  input  wire logic            avs_write_i,
  input  wire logic [31:0]     avs_writedata_i,
  input  wire logic [3:0]      avs_byteenable_i,
  output logic [31:0]          avs_readdata_o,
  output logic                 avs_waitrequest_o,
  // Limit switch pins, normally closed, high while closed
  input  wire logic            fwd_end_switch_i,
  input  wire logic            rev_end_switch_i,
  // Limits from the controller, same polarity
  input  wire logic            host_upper_limit_i,
  input  wire logic            host_lower_limit_i,
  // Operating context
  input  wire slim_mode_type   ctrl_mode_i,
  input  wire logic            pole_detect_i,
  input  wire logic            home_clear_en_i,
  // Commanded motion in address terms
  input  wire slim_motion_type motion_req_i,
  // Results
  output slim_motion_type      motion_allow_o,
  output logic                 upper_addr_limit_o,
  output logic                 lower_addr_limit_o,
  output logic                 limit_warn_o,
  output logic                 stop_req_o,
  output logic                 home_clear_o,
  output logic                 irq_o
);

  slim_state_type cur;
  slim_state_type next_cur;
  logic           honour;
  logic           up_hit;
  logic           up_allow;
  logic           up_stop;
  logic           lo_hit;
  logic           lo_allow;
  logic           lo_stop;

  // -----------------------------------------------------------------
  // Limit channels, one per address end
  // -----------------------------------------------------------------
  // Torque mode only honours limits while a linear pole search runs
  assign honour = (ctrl_mode_i != SLIM_MODE_TORQUE)
                | (cur.ctrl.linear & pole_detect_i);

  slim_limit_gate u_upper_gate (
    .dir0_sw_i (fwd_end_switch_i),
    .dir1_sw_i (rev_end_switch_i),
    .host_sw_i (host_upper_limit_i),
    .src_sel_i (cur.ctrl.src_sel),
    .dir_sel_i (cur.ctrl.dir_sel),
    .auto_on_i (cur.ctrl.auto_on),
    .honour_i  (honour),
    .req_i     (motion_req_i.inc_req),
    .hit_o     (up_hit),
    .allow_o   (up_allow),
    .stop_o    (up_stop)
  );

  slim_limit_gate u_lower_gate (
    .dir0_sw_i (rev_end_switch_i),
    .dir1_sw_i (fwd_end_switch_i),
    .host_sw_i (host_lower_limit_i),
    .src_sel_i (cur.ctrl.src_sel),
    .dir_sel_i (cur.ctrl.dir_sel),
    .auto_on_i (cur.ctrl.auto_on),
    .honour_i  (honour),
    .req_i     (motion_req_i.dec_req),
    .hit_o     (lo_hit),
    .allow_o   (lo_allow),
    .stop_o    (lo_stop)
  );

  // -----------------------------------------------------------------
  // Combinational next state
  // -----------------------------------------------------------------
  always_comb begin
    logic       hit_up;
    logic       hit_lo;
    logic       rd_evt;
    logic [4:0] wctrl;
    hit_up   = up_hit;
    hit_lo   = lo_hit;
    rd_evt   = 1'b0;
    wctrl    = 5'h00;
    next_cur = cur;
    next_cur.upper_act = hit_up;
    next_cur.lower_act = hit_lo;
    // Rotation view: CCW is address-increasing unless direction is 1
    next_cur.fwd_act = cur.ctrl.dir_sel ? hit_lo : hit_up;
    next_cur.rev_act = cur.ctrl.dir_sel ? hit_up : hit_lo;
    next_cur.allow.inc_req = up_allow;
    next_cur.allow.dec_req = lo_allow;
    next_cur.stop_req = up_stop | lo_stop;
    next_cur.warn = (hit_up | hit_lo) & ~cur.ctrl.warn_dis;
    // Clearing home is a pulse on a fresh limit stop
    next_cur.home_clear = next_cur.stop_req & ~cur.stop_req
                        & home_clear_en_i;

    // -------------------------------------------------------------
    // Bus slave: one wait cycle, answer on the second edge
    // -------------------------------------------------------------
    rd_evt = 1'b0;
    next_cur.waitreq = 1'b1;
    if ((avs_read_i | avs_write_i) & ~cur.busy) begin
      next_cur.busy    = 1'b1;
      next_cur.waitreq = 1'b0;
      if (avs_write_i) begin
        wctrl = avs_writedata_i[4:0];
        if (avs_address_i == SLIM_ADDR_CTRL && avs_byteenable_i[0]) begin
          next_cur.ctrl.dir_sel  = wctrl[SLIM_CTRL_DIR_BIT];
          next_cur.ctrl.src_sel  = wctrl[SLIM_CTRL_SRC_BIT];
          next_cur.ctrl.auto_on  = wctrl[SLIM_CTRL_AUTO_BIT];
          next_cur.ctrl.warn_dis = wctrl[SLIM_CTRL_WARN_BIT];
          next_cur.ctrl.linear   = wctrl[SLIM_CTRL_LINEAR_BIT];
        end
        if (avs_address_i == SLIM_ADDR_MASK && avs_byteenable_i[0]) begin
          next_cur.mask = avs_writedata_i[1:0];
        end
      end else begin
        next_cur.rdata = SLIM_UNMAPPED_DATA;
        case (avs_address_i)
          SLIM_ADDR_CTRL: begin
            next_cur.rdata[SLIM_CTRL_DIR_BIT]    = cur.ctrl.dir_sel;
            next_cur.rdata[SLIM_CTRL_SRC_BIT]    = cur.ctrl.src_sel;
            next_cur.rdata[SLIM_CTRL_AUTO_BIT]   = cur.ctrl.auto_on;
            next_cur.rdata[SLIM_CTRL_WARN_BIT]   = cur.ctrl.warn_dis;
            next_cur.rdata[SLIM_CTRL_LINEAR_BIT] = cur.ctrl.linear;
          end
          SLIM_ADDR_STATUS: begin
            next_cur.rdata[0] = cur.upper_act;
            next_cur.rdata[1] = cur.lower_act;
            next_cur.rdata[2] = cur.fwd_act;
            next_cur.rdata[3] = cur.rev_act;
            next_cur.rdata[4] = cur.warn;
            next_cur.rdata[5] = cur.stop_req;
          end
          SLIM_ADDR_EVENT: begin
            next_cur.rdata[1:0] = cur.event_sts;
            rd_evt = 1'b1;
          end
          SLIM_ADDR_MASK: begin
            next_cur.rdata[1:0] = cur.mask;
          end
          SLIM_ADDR_DINPUT: begin
            // Negative/positive are the address ends: rotation ends swapped back by direction
            next_cur.rdata[SLIM_DIN_NEG_BIT] =
              cur.ctrl.dir_sel ? cur.fwd_act : cur.rev_act;
            next_cur.rdata[SLIM_DIN_POS_BIT] =
              cur.ctrl.dir_sel ? cur.rev_act : cur.fwd_act;
          end
          default: begin
            next_cur.rdata = SLIM_UNMAPPED_DATA;
          end
        endcase
      end
    end else begin
      next_cur.busy = 1'b0;
    end

    // -------------------------------------------------------------
    // Sticky events: read clears, a new event in that cycle wins
    // -------------------------------------------------------------
    if (rd_evt) begin
      next_cur.event_sts = 2'b00;
    end
    next_cur.event_sts[SLIM_EV_UPPER_BIT] =
      next_cur.event_sts[SLIM_EV_UPPER_BIT] | (hit_up & ~cur.upper_act);
    next_cur.event_sts[SLIM_EV_LOWER_BIT] =
      next_cur.event_sts[SLIM_EV_LOWER_BIT] | (hit_lo & ~cur.lower_act);
    next_cur.irq = |(next_cur.event_sts & next_cur.mask);
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cur           <= '0;
      cur.ctrl      <= slim_ctrl_type'(SLIM_CTRL_RESET);
      cur.mask      <= SLIM_MASK_RESET;
      cur.waitreq   <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign motion_allow_o     = cur.allow;
  assign upper_addr_limit_o = cur.upper_act;
  assign lower_addr_limit_o = cur.lower_act;
  assign limit_warn_o       = cur.warn;
  assign stop_req_o         = cur.stop_req;
  assign home_clear_o       = cur.home_clear;
  assign irq_o              = cur.irq;
  assign avs_readdata_o     = cur.rdata;
  assign avs_waitrequest_o  = cur.waitreq;

endmodule : slim_top

`default_nettype wire

// [hw/slim_pkg.sv]
// Package for the stroke limit logic: register map, fields, types
package slim_pkg;

  // ---------------------------------------------------------------------
  // Register offsets (word addresses, one 32-bit word each)
  // ---------------------------------------------------------------------
  localparam logic [3:0] SLIM_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] SLIM_ADDR_STATUS = 4'h1;
  localparam logic [3:0] SLIM_ADDR_EVENT  = 4'h2;
  localparam logic [3:0] SLIM_ADDR_MASK   = 4'h3;
  localparam logic [3:0] SLIM_ADDR_DINPUT = 4'h4;

  // ---------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------
  localparam int SLIM_CTRL_DIR_BIT   = 0;
  localparam int SLIM_CTRL_SRC_BIT   = 1;
  localparam int SLIM_CTRL_AUTO_BIT  = 2;
  localparam int SLIM_CTRL_WARN_BIT  = 3;
  localparam int SLIM_CTRL_LINEAR_BIT = 4;
  localparam logic [4:0] SLIM_CTRL_RESET = 5'h00;

  // Event bits: 0 upper limit hit, 1 lower limit hit
  localparam int SLIM_EV_UPPER_BIT = 0;
  localparam int SLIM_EV_LOWER_BIT = 1;
  localparam logic [1:0] SLIM_MASK_RESET = 2'h0;

  // Digital input word: bit 0 negative limit, bit 1 positive limit
  localparam int SLIM_DIN_NEG_BIT = 0;
  localparam int SLIM_DIN_POS_BIT = 1;

  localparam logic [31:0] SLIM_UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [1:0] {
    SLIM_MODE_POSITION,
    SLIM_MODE_VELOCITY,
    SLIM_MODE_TORQUE
  } slim_mode_type;

  typedef struct packed {
    logic dir_sel;
    logic src_sel;
    logic auto_on;
    logic warn_dis;
    logic linear;
  } slim_ctrl_type;

  typedef struct packed {
    logic inc_req;
    logic dec_req;
  } slim_motion_type;

  typedef struct packed {
    slim_ctrl_type   ctrl;
    logic [1:0]      event_sts;
    logic [1:0]      mask;
    logic            upper_act;
    logic            lower_act;
    logic            fwd_act;
    logic            rev_act;
    slim_motion_type allow;
    logic            warn;
    logic            stop_req;
    logic            home_clear;
    logic            irq;
    logic            waitreq;
    logic [31:0]     rdata;
    logic            busy;
  } slim_state_type;

endpackage : slim_pkg

// [test/slim_sva.sv]
// Assertion checker for the stroke limit logic ports
`timescale 1ns/1ps
`default_nettype none
module slim_sva
  import slim_pkg::*;
(
  input wire logic            mclk_i,
  input wire logic            reset_i,
  input wire logic            avs_read_i,
  input wire logic            avs_write_i,
  input wire logic            avs_waitrequest_o,
  input wire slim_mode_type   ctrl_mode_i,
  input wire logic            pole_detect_i,
  input wire slim_motion_type motion_req_i,
  input wire slim_motion_type motion_allow_o,
  input wire logic            upper_addr_limit_o,
  input wire logic            lower_addr_limit_o,
  input wire logic            limit_warn_o,
  input wire logic            stop_req_o,
  input wire logic            home_clear_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_torque_drop:
  assert property (!$past(reset_i) && $past(ctrl_mode_i) == SLIM_MODE_TORQUE
    && !$past(pole_detect_i) |-> !upper_addr_limit_o && !lower_addr_limit_o)
    else $error("limit honoured in torque mode");
  a_pole_end:
  assert property (ctrl_mode_i == SLIM_MODE_TORQUE && $fell(pole_detect_i)
    |=> !upper_addr_limit_o && !lower_addr_limit_o)
    else $error("limit kept after pole detection");
  a_inc_gate:
  assert property (!$past(reset_i) |-> motion_allow_o.inc_req ==
    ($past(motion_req_i.inc_req) && !upper_addr_limit_o))
    else $error("increase gating wrong");
  a_dec_gate:
  assert property (!$past(reset_i) |-> motion_allow_o.dec_req ==
    ($past(motion_req_i.dec_req) && !lower_addr_limit_o))
    else $error("decrease gating wrong");
  a_stop_cause:
  assert property (!$past(reset_i) |-> stop_req_o ==
    (upper_addr_limit_o && $past(motion_req_i.inc_req) ||
     lower_addr_limit_o && $past(motion_req_i.dec_req)))
    else $error("stop request wrong");
  a_warn_cause:
  assert property (limit_warn_o |-> upper_addr_limit_o || lower_addr_limit_o)
    else $error("warning without limit");
  a_home_pulse:
  assert property (home_clear_o |=> !home_clear_o)
    else $error("home clear longer than one cycle");
  a_bus_answer:
  assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |-> ##[1:3] !avs_waitrequest_o) else $error("bus answer late");
endmodule : slim_sva
bind slim_top slim_sva u_sva (.mclk_i, .reset_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .ctrl_mode_i, .pole_detect_i, .motion_req_i,
  .motion_allow_o, .upper_addr_limit_o, .lower_addr_limit_o, .limit_warn_o,
  .stop_req_o, .home_clear_o);
`default_nettype wire

// [test/slim_host_model.sv]
// Axis model: host controller limits and normally closed end switches
`timescale 1ns/1ps
`default_nettype none
module slim_host_model
  import slim_pkg::*;
(
  input  wire logic            mclk_i,
  input  wire logic            reset_i,
  input  wire logic            dir_i,
  input  wire slim_motion_type allow_i,
  output logic                 fwd_o,
  output logic                 rev_o,
  output logic                 host_upper_o,
  output logic                 host_lower_o
);
  int pos;
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) pos <= 8;
    else if (allow_i.inc_req && pos < 15) pos <= pos + 1;
    else if (allow_i.dec_req && pos > 0) pos <= pos - 1;
  end
  // Contacts open only at the ends; direction 1 puts CCW at low address
  assign fwd_o = dir_i ? !(pos <= 3) : !(pos >= 12);
  assign rev_o = dir_i ? !(pos >= 12) : !(pos <= 3);
  assign host_upper_o = !(pos >= 12);
  assign host_lower_o = !(pos <= 3);
endmodule : slim_host_model
`default_nettype wire

// [test/slim_top_tb_top.sv]
// Self-checking bench for the stroke limit logic
`timescale 1ns/1ps
`default_nettype none
module slim_top_tb_top;
  import slim_pkg::*;
  logic mclk_i = 0, reset_i = 1, rd = 0, wr = 0, pole = 0, hce = 0, on = 0;
  logic fw, rv, hu, hl, up, lo, wn, st, hc, irq, wreq;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, q, rdat, r = 32'h0001_60B0;
  logic [4:0] ctl = 5'h00;
  logic [6:0] e;
  slim_mode_type md = SLIM_MODE_POSITION;
  slim_motion_type mr = '0, al;
  int n_mismatch = 0, n_tests = 0;
  always #2.5 mclk_i = ~mclk_i;
  slim_top u_dut (.mclk_i, .reset_i, .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .fwd_end_switch_i(fw),
    .rev_end_switch_i(rv), .host_upper_limit_i(hu), .host_lower_limit_i(hl),
    .ctrl_mode_i(md), .pole_detect_i(pole), .home_clear_en_i(hce),
    .motion_req_i(mr), .motion_allow_o(al), .upper_addr_limit_o(up),
    .lower_addr_limit_o(lo), .limit_warn_o(wn), .stop_req_o(st),
    .home_clear_o(hc), .irq_o(irq));
  slim_host_model u_host (.mclk_i, .reset_i, .dir_i(ctl[0]), .allow_i(al),
    .fwd_o(fw), .rev_o(rv), .host_upper_o(hu), .host_lower_o(hl));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do @(posedge mclk_i); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // ---------------------------------------------------------------------
  // Reference model, one result per clock
  // ---------------------------------------------------------------------
  always @(posedge mclk_i) begin : ref_model
    logic h, u, l, s;
    h = md != SLIM_MODE_TORQUE || (ctl[4] && pole);
    u = ctl[1] ? !hu : (ctl[0] ? !rv : !fw) && !ctl[2];
    l = ctl[1] ? !hl : (ctl[0] ? !fw : !rv) && !ctl[2];
    u = u && h;
    l = l && h;
    s = u & mr.inc_req | l & mr.dec_req;
    e <= {s & !e[5] & hce, s, (u | l) & !ctl[3],
          mr.inc_req & !u, mr.dec_req & !l, l, u};
  end
  always @(negedge mclk_i) if (on) begin
    chk("upper", e[0], up);
    chk("lower", e[1], lo);
    chk("allow", e[3:2], al);
    chk("warn", e[4], wn);
    chk("stop", e[5], st);
    chk("home_clear", e[6], hc);
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    // Every control setting, random motion and modes under each
    for (int c = 0; c < 32; c++) begin
      on = 0;
      bus(1'b1, SLIM_ADDR_CTRL, 32'(c));
      ctl <= 5'(c);
      repeat (2) @(posedge mclk_i);
      on = 1;
      repeat (150) begin
        @(posedge mclk_i);
        r = xs(r);
        mr <= r[1:0];
        pole <= r[2];
        hce <= r[3];
        if (r[7:4] == 4'h0) md <= slim_mode_type'(r[9:8] % 2'd3);
      end
    end
    @(posedge mclk_i);
    on = 0;
    md <= SLIM_MODE_POSITION;
    mr <= 2'b01;
    ctl <= 5'h10;
    bus(1'b1, SLIM_ADDR_CTRL, 32'h0000_0010);
    repeat (20) @(posedge mclk_i);
    // Clear old events at the low end, then run into the high end
    bus(1'b0, SLIM_ADDR_EVENT, 32'h0000_0000);
    mr <= 2'b10;
    repeat (20) @(posedge mclk_i);
    mr <= '0;
    repeat (3) @(posedge mclk_i);
    chk("irq_masked", 32'(1'b0), 32'(irq));
    bus(1'b0, SLIM_ADDR_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0015, q);
    bus(1'b0, SLIM_ADDR_DINPUT, 32'h0000_0000);
    chk("dinput", 32'h0000_0002, q);
    bus(1'b0, SLIM_ADDR_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0010, q);
    bus(1'b1, SLIM_ADDR_MASK, 32'h0000_0003);
    repeat (2) @(posedge mclk_i);
    chk("irq_set", 32'(1'b1), 32'(irq));
    bus(1'b0, SLIM_ADDR_EVENT, 32'h0000_0000);
    chk("event", 32'h0000_0001, q);
    repeat (2) @(posedge mclk_i);
    chk("irq_clear", 32'(1'b0), 32'(irq));
    // Direction 1 puts the reverse pin at the high address end
    ctl <= 5'h01;
    bus(1'b1, SLIM_ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge mclk_i);
    bus(1'b0, SLIM_ADDR_STATUS, 32'h0000_0000);
    chk("status_dir1", 32'h0000_0019, q);
    bus(1'b0, SLIM_ADDR_DINPUT, 32'h0000_0000);
    chk("dinput_dir1", 32'h0000_0002, q);
    bus(1'b0, 4'hF, 32'h0000_0000);
    chk("unmapped", SLIM_UNMAPPED_DATA, q);
    conclude();
  end
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule : slim_top_tb_top
`default_nettype wire
